/* File: rtl/gpc_pkg.sv */
// Purpose: shared constants, types and decoders for the general pin register block
// Assumes: 16-bit serial frames, MSB first, registers 8 bits wide
// Notes: readback address field position and main control write address are local choices

package gpc_pkg;

  // ----------------------------------------
  // frame and register geometry
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int REG_W = 8;
  localparam int NUM_PINS = 4;
  localparam int NUM_SHARED = 3;
  localparam int NIB_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  // ----------------------------------------
  // frame fields
  // ----------------------------------------
  localparam int PFX_MSB = 15;
  localparam int PFX_LSB = 12;
  localparam int EADDR_MSB = 11;
  localparam int EADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int RDADDR_MSB = 11;
  localparam int RDADDR_LSB = 7;
  localparam logic [3:0] EXT_PREFIX = 4'hF;
  localparam logic [3:0] MAIN_CTRL_WADDR = 4'h1;

  // ----------------------------------------
  // register addresses and reset values
  // ----------------------------------------
  localparam logic [3:0] EXT_CTRL_A = 4'h0;
  localparam logic [3:0] EXT_CTRL_B = 4'h1;
  localparam logic [3:0] EXT_LEVELS = 4'h2;
  localparam logic [4:0] RD_CTRL_A = 5'h1B;
  localparam logic [4:0] RD_CTRL_B = 5'h1C;
  localparam logic [4:0] RD_LEVELS = 5'h1D;
  localparam logic [4:0] RD_ADDR_RST = 5'h00;
  localparam logic [REG_W-1:0] REG_RST = 8'h00;
  localparam logic [REG_W-1:0] CTRL_B_MASK = 8'hF7;
  localparam logic [REG_W-1:0] LEVELS_MASK = 8'hF0;
  localparam logic [FRAME_BITS-1:0] FRAME_RST = 16'h0000;

  // ----------------------------------------
  // control nibble fields
  // ----------------------------------------
  localparam int FLD_ALERT = 0;
  localparam int FLD_DIR = 1;
  localparam int FLD_POL = 2;
  localparam int FLD_ROLE = 3;

  typedef enum logic [0:0] {
    GPC_IDLE = 1'b0,
    GPC_SHIFT = 1'b1
  } gpc_state_e;

  // control nibble of pin idx (0 = general pin 1)
  function automatic logic [NIB_W-1:0] gpc_ctrl_nibble(
    input logic [REG_W-1:0] ctrl_a,
    input logic [REG_W-1:0] ctrl_b,
    input int idx
  );
    logic [NIB_W-1:0] nib;
    nib = ctrl_b[3:0];
    case (idx)
      0: nib = ctrl_a[7:4];
      1: nib = ctrl_a[3:0];
      2: nib = ctrl_b[7:4];
      default: nib = ctrl_b[3:0];
    endcase
    return nib;
  endfunction

endpackage

/* File: rtl/gpc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes: first stage feeds only the second stage

`timescale 1ns/100ps

module gpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // a change counts only once the second and third stage agree
  always_comb
  begin
    next_level = (stage2 & stage3) | (level & (stage2 ^ stage3));
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule

/* File: rtl/gpc_pin_cell.sv */
// Purpose: per-pin direction, polarity, role and alert decode
// Assumes: control nibble and data bit come from registers
// Notes: a dedicated pin has no role bit and is always a general pin

`timescale 1ns/100ps

module gpc_pin_cell
  import gpc_pkg::*;
#(
  parameter bit SHARED = 1'b1
) (
  input wire logic [gpc_pkg::NIB_W-1:0] ctrl,
  input wire logic level_bit,
  input wire logic pin_sampled,
  output logic pin_out,
  output logic pin_oe,
  output logic read_bit,
  output logic alert_term,
  output logic aux_select
);

  logic is_general;
  logic is_input;

  always_comb
  begin
    is_general = SHARED ? ctrl[FLD_ROLE] : 1'b1;
    aux_select = ~is_general;
    is_input = ctrl[FLD_DIR];
    // analog role leaves the pin undriven so the converter sees it clean
    pin_oe = is_general & ~is_input;
    pin_out = level_bit;
    read_bit = (is_general & is_input) ? pin_sampled : level_bit;
    alert_term = is_general & is_input & ctrl[FLD_ALERT] & (pin_sampled == ctrl[FLD_POL]);
  end

endmodule

/* File: rtl/gpc_gpio_regs.sv */
// Purpose: general pin control and data registers behind the serial port
// Assumes: serial clock, select and data arrive asynchronously and are sampled
// Notes: serial clock must stay well below core_clk / 8 for clean sampling

`timescale 1ns/100ps

// Overview of operation
// - control a: ext write 0, read 11011
// - a bit0 gates pin 2 onto alert
// - a bit1 sets pin 2 direction
// - a bit2 sets pin 2 polarity
// - a bit3 picks analog 2 or pin 2
// - a bit4 gates pin 1 onto alert
// - a bit5 sets pin 1 direction
// - a bit6 sets pin 1 polarity
// - a bit7 picks analog 1 or pin 1
// - control b: ext write 1, read 11100
// - b bit0 gates pin 4 onto alert
// - b bit1 sets pin 4 direction
// - b bit2 sets pin 4 polarity
// - b bit4 gates pin 3 onto alert
// - b bit5 sets pin 3 direction
// - b bit6 sets pin 3 polarity
// - b bit7 picks analog 3 or pin 3
// - levels: ext write 2, read 11101, bits 7..4
module gpc_gpio_regs
  import gpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_sel_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
  output logic [gpc_pkg::NUM_PINS-1:0] pin_out,
  output logic [gpc_pkg::NUM_PINS-1:0] pin_oe,
  output logic [gpc_pkg::NUM_SHARED-1:0] aux_select,
  output logic alert
);

  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  logic [2:0] ser_level;
  logic [NUM_PINS-1:0] pin_sampled;
  logic sclk_lvl;
  logic sel_n_lvl;
  logic din_lvl;

  // select passes inverted so the synchroniser's reset value is the idle level;
  // otherwise a false frame start would follow every reset
  gpc_sync #(
    .WIDTH(3)
  ) u_ser_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({ser_clk, ~ser_sel_n, ser_din}),
    .level(ser_level)
  );

  // pin levels take about four core cycles to reach readback and alert
  gpc_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .level(pin_sampled)
  );

  assign sclk_lvl = ser_level[2];
  assign sel_n_lvl = ~ser_level[1];
  assign din_lvl = ser_level[0];

  // ----------------------------------------
  // registers and pin cells
  // ----------------------------------------
  logic [REG_W-1:0] pin_control_a;
  logic [REG_W-1:0] pin_control_b;
  logic [REG_W-1:0] pin_levels;
  logic [4:0] readback_addr;
  logic [NUM_PINS-1:0] read_bits;
  logic [NUM_PINS-1:0] alert_terms;
  logic [NUM_PINS-1:0] cell_aux;
  logic [REG_W-1:0] levels_view;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      // pin index gi maps to levels bit 7-gi; pin 4 has no role bit
      gpc_pin_cell #(
        .SHARED(gi < NUM_SHARED)
      ) u_cell (
        .ctrl(gpc_ctrl_nibble(pin_control_a, pin_control_b, gi)),
        .level_bit(pin_levels[REG_W-1-gi]),
        .pin_sampled(pin_sampled[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .read_bit(read_bits[gi]),
        .alert_term(alert_terms[gi]),
        .aux_select(cell_aux[gi])
      );
      assign levels_view[REG_W-1-gi] = read_bits[gi];
    end
  endgenerate

  assign levels_view[3:0] = REG_RST[3:0];
  assign aux_select = cell_aux[NUM_SHARED-1:0];

  // readback word for the next frame; unmapped addresses read zero
  function automatic logic [REG_W-1:0] gpc_read_mux(
    input logic [4:0] addr,
    input logic [REG_W-1:0] a,
    input logic [REG_W-1:0] b,
    input logic [REG_W-1:0] lev
  );
    logic [REG_W-1:0] v;
    v = REG_RST;
    if (addr == RD_CTRL_A)
      v = a;
    else if (addr == RD_CTRL_B)
      v = b;
    else if (addr == RD_LEVELS)
      v = lev;
    return v;
  endfunction

  // ----------------------------------------
  // serial frame engine
  // ----------------------------------------
  gpc_state_e state;
  gpc_state_e next_state;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] next_shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [FRAME_BITS-1:0] next_shift_out;
  logic sclk_prev;
  logic next_ser_dout;
  logic [REG_W-1:0] next_control_a;
  logic [REG_W-1:0] next_control_b;
  logic [REG_W-1:0] next_levels;
  logic [4:0] next_readback_addr;
  logic next_alert;
  logic [FRAME_BITS-1:0] word;
  logic sclk_rise;
  logic sclk_fall;
  logic commit;

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_ser_dout = ser_dout;
    commit = 1'b0;
    word = {shift_in[FRAME_BITS-2:0], din_lvl};
    // edges come from filtered levels, so a serial clock glitch seen at only one core clock edge is dropped
    sclk_rise = sclk_lvl & ~sclk_prev;
    sclk_fall = ~sclk_lvl & sclk_prev;
    unique case (state)
      GPC_IDLE:
      begin
        if (!sel_n_lvl)
        begin
          // load readback first so the host gets it in this frame
          next_state = GPC_SHIFT;
          next_bit_cnt = CNT_ZERO;
          next_shift_out = {REG_RST, gpc_read_mux(readback_addr, pin_control_a,
                            pin_control_b, levels_view)};
          next_ser_dout = next_shift_out[FRAME_BITS-1];
        end
      end
      GPC_SHIFT:
      begin
        if (sel_n_lvl)
        begin
          // a short frame is dropped without touching any register
          next_state = GPC_IDLE;
        end
        else
        begin
          if (sclk_fall)
          begin
            next_shift_out = {shift_out[FRAME_BITS-2:0], 1'b0};
            next_ser_dout = next_shift_out[FRAME_BITS-1];
          end
          if (sclk_rise && (bit_cnt <= LAST_BIT))
          begin
            next_shift_in = word;
            next_bit_cnt = bit_cnt + CNT_ONE;
            // only the sixteenth rising edge commits, later edges are ignored
            commit = (bit_cnt == LAST_BIT);
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= GPC_IDLE;
      bit_cnt <= CNT_ZERO;
      shift_in <= FRAME_RST;
      shift_out <= FRAME_RST;
      sclk_prev <= 1'b0;
      ser_dout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      sclk_prev <= sclk_lvl;
      ser_dout <= next_ser_dout;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // writes land only on a full frame, so a cut frame leaves every register as it was;
  // a prefix that matches neither form is ignored
  always_comb
  begin
    next_control_a = pin_control_a;
    next_control_b = pin_control_b;
    next_levels = pin_levels;
    next_readback_addr = readback_addr;
    if (commit)
    begin
      if (word[PFX_MSB:PFX_LSB] == EXT_PREFIX)
      begin
        if (word[EADDR_MSB:EADDR_LSB] == EXT_CTRL_A)
          next_control_a = word[DATA_MSB:DATA_LSB];
        else if (word[EADDR_MSB:EADDR_LSB] == EXT_CTRL_B)
          next_control_b = word[DATA_MSB:DATA_LSB] & CTRL_B_MASK;
        else if (word[EADDR_MSB:EADDR_LSB] == EXT_LEVELS)
          next_levels = word[DATA_MSB:DATA_LSB] & LEVELS_MASK;
      end
      else if (word[PFX_MSB:PFX_LSB] == MAIN_CTRL_WADDR)
      begin
        next_readback_addr = word[RDADDR_MSB:RDADDR_LSB];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_control_a <= REG_RST;
      pin_control_b <= REG_RST;
      pin_levels <= REG_RST;
      readback_addr <= RD_ADDR_RST;
    end
    else
    begin
      pin_control_a <= next_control_a;
      pin_control_b <= next_control_b;
      pin_levels <= next_levels;
      readback_addr <= next_readback_addr;
    end
  end

  // ----------------------------------------
  // alert
  // ----------------------------------------
  // registered so that a glitch across the pin cells never reaches the pin;
  // the cost is one core cycle of extra latency
  always_comb
  begin
    next_alert = |alert_terms;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert <= 1'b0;
    end
    else
    begin
      alert <= next_alert;
    end
  end

  // output driven only inside a frame so the line can be shared
  assign ser_dout_oe = (state == GPC_SHIFT);

endmodule

/* File: bench/gpc_gpio_regs_props.sv */
// Purpose: port checks for the general pin register block
// Assumes: sees only the top ports
// Notes: config may only move near a frame
`timescale 1ns/100ps
module gpc_gpio_regs_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_sel_n,
  input wire logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [gpc_pkg::NUM_SHARED-1:0] aux_select,
  input wire logic alert
);
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic [3:0] pin_prev;
  // ----
  // helper counters, saturating so they never wrap
  // ----
  always_comb
  begin
    next_idle_cnt = ser_sel_n ? idle_cnt + {3'h0, idle_cnt != 4'hF} : 4'h0;
    next_quiet = (pin_in == pin_prev) ? quiet + {3'h0, quiet != 4'hF} : 4'h0;
  end
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      idle_cnt <= 4'h0;
      quiet <= 4'h0;
      pin_prev <= 4'h0;
    end
    else
    begin
      idle_cnt <= next_idle_cnt;
      quiet <= next_quiet;
      pin_prev <= pin_in;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_values: assert property ($rose(rst_n) |-> pin_oe == 4'h8 && aux_select == 3'h7 && pin_out == 4'h0
    && !alert) else $error("bad state after reset");
  a_output_not_aux: assert property ((pin_oe[2:0] & aux_select) == 3'h0)
    else $error("shared pin driven in analog role");
  a_alert_has_input: assert property (alert |-> $past(~(pin_oe | {1'b0, aux_select})) != 4'h0)
    else $error("alert with no general input pin");
  a_alert_steady: assert property (idle_cnt == 4'hF && quiet > 4'h7 |-> $stable(alert))
    else $error("alert moved with pins and config quiet");
  a_cfg_idle_stable: assert property (idle_cnt == 4'hF |-> $stable(pin_out) && $stable(pin_oe)
    && $stable(aux_select)) else $error("config moved outside a frame");
  a_dout_idle_off: assert property (idle_cnt > 4'h7 |-> !ser_dout_oe)
    else $error("output enabled outside a frame");
  a_dout_frame_on: assert property ($fell(ser_sel_n) |-> ##[1:8] ser_dout_oe)
    else $error("output not enabled in frame");
  a_dout_oe_hold: assert property ((!ser_sel_n)[*6] ##0 ser_dout_oe |=> ser_dout_oe)
    else $error("output enable dropped mid frame");
endmodule

/* File: bench/gpc_host_model.sv */
// Purpose: host side of the serial port
// Assumes: driven on core_clk falling edges
// Notes: each serial half period is 6 core cycles
`timescale 1ns/100ps
module gpc_host_model (
  input wire logic core_clk,
  output logic ser_clk,
  output logic ser_sel_n,
  output logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  output logic [15:0] rx_word,
  output logic rx_stb
);
  initial
  begin
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_din = 1'b0;
    rx_word = 16'h0000;
    rx_stb = 1'b0;
  end
  // one 16-bit frame, MSB first; clock idles low between frames
  task automatic xfer(input logic [15:0] w, input bit chk);
    logic [15:0] r;
    r = 16'h0000;
    ser_sel_n = 1'b0;
    repeat (6) @(negedge core_clk);
    for (int i = 15; i >= 0; i--)
    begin
      ser_din = w[i];
      repeat (6) @(negedge core_clk);
      ser_clk = 1'b1;
      repeat (6) @(negedge core_clk);
      r[i] = ser_dout_oe ? ser_dout : 1'bz;
      ser_clk = 1'b0;
    end
    repeat (6) @(negedge core_clk);
    ser_sel_n = 1'b1;
    ser_din = ~ser_din;
    rx_word = r;
    rx_stb = chk;
    @(negedge core_clk);
    rx_stb = 1'b0;
    repeat (20) @(negedge core_clk);
  endtask
endmodule

/* File: bench/gpc_gpio_regs_tb.sv */
// Purpose: self-checking bench for the general pin registers
// Assumes: host model drives the serial port
// Notes: random config, levels and pin inputs each round
`timescale 1ns/100ps
bind gpc_gpio_regs gpc_gpio_regs_props u_props (.core_clk, .rst_n, .ser_clk, .ser_sel_n, .ser_din, .ser_dout,
  .ser_dout_oe, .pin_in, .pin_out, .pin_oe, .aux_select, .alert);
module gpc_gpio_regs_tb;
  import gpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ser_clk, ser_sel_n, ser_din, ser_dout, ser_dout_oe, alert, rx_stb;
  logic [3:0] pin_in = 4'h0;
  logic [3:0] pin_out, pin_oe;
  logic [2:0] aux_select;
  logic [15:0] rx_word;
  logic [15:0] exp_q[$];
  logic smp = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] b = 8'h00;
  logic [7:0] lev = 8'h00;
  int failures = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  gpc_gpio_regs dut (.core_clk, .rst_n, .ser_clk, .ser_sel_n, .ser_din, .ser_dout, .ser_dout_oe, .pin_in,
    .pin_out, .pin_oe, .aux_select, .alert);
  gpc_host_model host (.core_clk, .ser_clk, .ser_sel_n, .ser_din, .ser_dout, .ser_dout_oe, .rx_word, .rx_stb);
  function automatic logic [3:0] nib(input int i);
    case (i)
      0: return a[7:4];
      1: return a[3:0];
      2: return b[7:4];
      default: return b[3:0];
    endcase
  endfunction
  // pin 4 has no role bit, so it is always general
  function automatic logic [15:0] pins_exp();
    logic [3:0] n, oe, gen;
    logic al;
    al = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      n = nib(i);
      gen[i] = (i == 3) | n[3];
      oe[i] = gen[i] & !n[1];
      if (gen[i] && n[1] && n[0] && pin_in[i] == n[2]) al = 1'b1;
    end
    return {lev[4], lev[5], lev[6], lev[7], oe, 1'b0, ~gen[2:0], 3'h0, al};
  endfunction
  function automatic logic [7:0] lev_rd();
    logic [7:0] r;
    logic [3:0] n;
    r = lev;
    for (int i = 0; i < 4; i++)
    begin
      n = nib(i);
      if ((i == 3 || n[3]) && n[1]) r[7-i] = pin_in[i];
    end
    return r;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge core_clk)
    if (rx_stb || smp) check(rx_stb ? rx_word : {pin_out, pin_oe, 1'b0, aux_select, 3'h0, alert}, exp_q.pop_front());
  task automatic pins;
    exp_q.push_back(pins_exp());
    smp = 1'b1;
    @(negedge core_clk);
    smp = 1'b0;
  endtask
  task automatic rd(input logic [4:0] ad, input logic [7:0] e);
    host.xfer({4'h1, ad, 7'h00}, 1'b0);
    exp_q.push_back({8'h00, e});
    host.xfer(16'h0000, 1'b1);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    host.xfer({4'hF, ad, d}, 1'b0);
  endtask
  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #1400000;
    failures++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(45204));
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    pins();
    rd(RD_CTRL_A, 8'h00);
    rd(RD_CTRL_B, 8'h00);
    rd(RD_LEVELS, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 16; k++)
    begin
      a = 8'($urandom);
      b = 8'($urandom);
      lev = 8'($urandom);
      pin_in = 4'($urandom);
      wr(EXT_CTRL_A, a);
      wr(EXT_CTRL_B, b);
      wr(EXT_LEVELS, lev);
      wr(4'h3, 8'hFF);
      b = b & 8'hF7;
      lev = lev & 8'hF0;
      pins();
      rd(RD_CTRL_A, a);
      rd(RD_CTRL_B, b);
      rd(RD_LEVELS, lev_rd());
      rd(5'h1E, 8'h00);
    end
    $display("random config test done");
    rst_n = 1'b0;
    a = 8'h00;
    b = 8'h00;
    lev = 8'h00;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    pins();
    rd(RD_CTRL_A, 8'h00);
    $display("second reset test done");
    end_of_test();
  end
endmodule
